// *** src/wire_master_core.sv ***
`timescale 1ns/1ps
module wire_master_core #(
  parameter int HALF_CYC = wire_iface_pkg::HALF_BIT_CYC
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // Control register write
  input  wire logic                     ctrl_write,
  input  wire logic                     ctrl_flag_clear,
  input  wire logic                     ctrl_start,
  input  wire logic                     ctrl_stop,
  input  wire logic                     ctrl_enable,
  input  wire logic                     ctrl_ack_en,
  input  wire logic [1:0]               ctrl_prescale,
  // Data register write
  input  wire logic                     data_write,
  input  wire logic [7:0]               data_in,
  // Status
  output logic                          op_done,
  output logic                          start_pending,
  output logic                          stop_pending,
  output logic                          write_collision,
  output logic                          bus_owned,
  output logic [7:0]                    wire_status_register,
  output logic [7:0]                    wire_data_register,
  output wire_iface_pkg::role_type      role,
  // Received bytes
  output logic                          rx_valid,
  input  wire logic                     rx_ready,
  output logic [7:0]                    rx_data,
  // Bus pins
  input  wire logic                     scl_in,
  output logic                          scl_out,
  output logic                          scl_oe_n,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe_n
);
  import wire_iface_pkg::*;

  localparam int CW = $clog2(HALF_CYC);

  if (HALF_CYC < 2) begin : g_chk
    $error("HALF_CYC must be at least 2");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic scl_meta_r, scl_sync_r, sda_meta_r, sda_sync_r;

  // Two flops per pin; only the second stage is read.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_meta_r <= 1'b1;
      scl_sync_r <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_sync_r <= 1'b1;
    end else begin
      scl_meta_r <= scl_in;
      scl_sync_r <= scl_meta_r;
      sda_meta_r <= sda_in;
      sda_sync_r <= sda_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  logic [7:0] mem_r [2];
  logic [7:0] mem_nxt [2];
  logic       wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic [1:0] fcnt_r, fcnt_nxt;
  logic       push, pop, fifo_room;
  logic [7:0] shift_r, shift_nxt;

  assign fifo_room = (fcnt_r != 2'h2);
  assign pop       = rx_valid && rx_ready;

  // Two entries let software drain one byte while the next arrives.
  always_comb begin
    mem_nxt  = mem_r;
    wptr_nxt = wptr_r;
    rptr_nxt = rptr_r;
    if (push) begin
      mem_nxt[wptr_r] = shift_r;
      wptr_nxt        = ~wptr_r;
    end
    if (pop) begin
      rptr_nxt = ~rptr_r;
    end
    fcnt_nxt = 2'(fcnt_r + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mem_r[0] <= DATA_RESET;
      mem_r[1] <= DATA_RESET;
      wptr_r   <= 1'b0;
      rptr_r   <= 1'b0;
      fcnt_r   <= 2'h0;
    end else begin
      mem_r  <= mem_nxt;
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      fcnt_r <= fcnt_nxt;
    end
  end

  assign rx_valid = (fcnt_r != 2'h0);
  assign rx_data  = mem_r[rptr_r];

  // ----------------------------------------------------------------
  // Control and bus sequencer
  // ----------------------------------------------------------------
  state_type   state_r, state_nxt;
  role_type    role_r, role_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic [7:0]  data_r, data_nxt;
  logic [4:0]  code_r, code_nxt;
  logic [1:0]  pre_r, pre_nxt;
  logic        done_r, done_nxt, set_ev;
  logic        start_r, start_nxt, stop_r, stop_nxt;
  logic        en_r, en_nxt, acken_r, acken_nxt;
  logic        wcol_r, wcol_nxt, own_r, own_nxt;
  logic        addr_r, addr_nxt, rxb_r, rxb_nxt;
  logic        scl_drv_r, scl_drv_nxt, sda_drv_r, sda_drv_nxt;
  logic        tick, sda_ack;

  assign tick = (cnt_r == CW'(HALF_CYC - 1));

  // Whether SDA is pulled low in a bit cell of the current byte.
  function automatic logic bit_low(input logic [3:0] idx,
                                   input logic [7:0] sh,
                                   input logic rx, input logic ae);
    if (idx == ACK_BIT_IDX) begin
      bit_low = rx && ae;
    end else begin
      bit_low = !rx && !sh[7];
    end
  endfunction

  always_comb begin
    state_nxt = state_r;
    role_nxt  = role_r;
    cnt_nxt   = tick ? '0 : CW'(cnt_r + 1'b1);
    bit_nxt   = bit_r;
    shift_nxt = shift_r;
    data_nxt  = data_r;
    code_nxt  = code_r;
    pre_nxt   = pre_r;
    start_nxt = start_r;
    stop_nxt  = stop_r;
    en_nxt    = en_r;
    acken_nxt = acken_r;
    wcol_nxt  = wcol_r;
    own_nxt   = own_r;
    addr_nxt  = addr_r;
    rxb_nxt   = rxb_r;
    set_ev    = 1'b0;
    push      = 1'b0;
    sda_ack   = !sda_sync_r;
    if (ctrl_write) begin
      start_nxt = ctrl_start;
      stop_nxt  = ctrl_stop;
      en_nxt    = ctrl_enable;
      acken_nxt = ctrl_ack_en;
      pre_nxt   = ctrl_prescale;
    end
    // The data register only takes writes while the flag is up.
    if (data_write) begin
      if (done_r) begin
        data_nxt = data_in;
        wcol_nxt = 1'b0;
      end else begin
        wcol_nxt = 1'b1;
      end
    end
    unique case (state_r)
      S_IDLE: begin
        cnt_nxt = '0;
        if (en_r && !done_r && start_r && scl_sync_r && sda_sync_r) begin
          state_nxt = S_START3;
        end
      end
      S_START1: begin
        if (tick) begin
          state_nxt = S_START2;
        end
      end
      S_START2, S_STOP2: begin
        // A slave holding SCL low delays the high phase; its count restarts.
        if (!scl_sync_r) begin
          cnt_nxt = '0;
        end else if (tick) begin
          state_nxt = (state_r == S_START2) ? S_START3 : S_STOP3;
        end
      end
      S_START3: begin
        if (tick) begin
          set_ev    = 1'b1;
          code_nxt  = own_r ? CODE_RSTART : CODE_START;
          start_nxt = 1'b0;
          own_nxt   = 1'b1;
          addr_nxt  = 1'b1;
          state_nxt = S_HOLD;
        end
      end
      S_HOLD: begin
        cnt_nxt = '0;
        if (!done_r) begin
          if (!en_r) begin
            own_nxt   = 1'b0;
            role_nxt  = ROLE_NONE;
            state_nxt = S_IDLE;
          end else if (stop_r) begin
            state_nxt = S_STOP1;
          end else if (start_r) begin
            state_nxt = S_START1;
          end else begin
            rxb_nxt   = !addr_r && (role_r == ROLE_MASTER_RX);
            shift_nxt = data_r;
            bit_nxt   = '0;
            state_nxt = S_BIT_LO;
          end
        end
      end
      S_BIT_LO: begin
        if (tick) begin
          state_nxt = S_BIT_HI;
        end
      end
      S_BIT_HI: begin
        if (!scl_sync_r) begin
          cnt_nxt = '0;
        end else if (tick && bit_r != ACK_BIT_IDX) begin
          shift_nxt = {shift_r[6:0], sda_sync_r};
          bit_nxt   = 4'(bit_r + 1'b1);
          state_nxt = S_BIT_LO;
        end else if (tick && !(rxb_r && !fifo_room)) begin
          set_ev    = 1'b1;
          state_nxt = S_HOLD;
          addr_nxt  = 1'b0;
          if (addr_r) begin
            if (data_r[DIR_BIT] == DIR_READ) begin
              role_nxt = ROLE_MASTER_RX;
              code_nxt = sda_ack ? CODE_ADDR_R_ACK : CODE_ADDR_R_NACK;
            end else begin
              role_nxt = ROLE_MASTER_TX;
              code_nxt = sda_ack ? CODE_ADDR_W_ACK : CODE_ADDR_W_NACK;
            end
          end else if (rxb_r) begin
            push     = 1'b1;
            data_nxt = shift_r;
            code_nxt = acken_r ? CODE_RX_ACK : CODE_RX_NACK;
          end else begin
            code_nxt = sda_ack ? CODE_DATA_ACK : CODE_DATA_NACK;
          end
        end else if (tick) begin
          // Buffer full: hold the clock high phase until room.
          cnt_nxt = cnt_r;
        end
      end
      S_STOP1: begin
        if (tick) begin
          state_nxt = S_STOP2;
        end
      end
      S_STOP3: begin
        if (tick) begin
          stop_nxt  = 1'b0;
          own_nxt   = 1'b0;
          role_nxt  = ROLE_NONE;
          code_nxt  = CODE_IDLE;
          state_nxt = S_IDLE;
        end
      end
    endcase
    done_nxt = set_ev || (done_r && !(ctrl_write && ctrl_flag_clear));
    scl_drv_nxt = (state_nxt == S_START1) || (state_nxt == S_BIT_LO) ||
                  (state_nxt == S_HOLD) || (state_nxt == S_STOP1);
    unique case (state_nxt)
      S_START3, S_STOP1, S_STOP2: sda_drv_nxt = 1'b1;
      S_HOLD:                     sda_drv_nxt = sda_drv_r;
      S_BIT_LO, S_BIT_HI: sda_drv_nxt = bit_low(bit_nxt, shift_nxt,
                                                 rxb_nxt, acken_nxt);
      default:                    sda_drv_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r   <= S_IDLE;
      role_r    <= ROLE_NONE;
      cnt_r     <= '0;
      bit_r     <= '0;
      shift_r   <= DATA_RESET;
      data_r    <= DATA_RESET;
      code_r    <= CODE_IDLE;
      pre_r     <= PRESCALE_RESET;
      done_r    <= 1'b0;
      start_r   <= 1'b0;
      stop_r    <= 1'b0;
      en_r      <= 1'b0;
      acken_r   <= 1'b0;
      wcol_r    <= 1'b0;
      own_r     <= 1'b0;
      addr_r    <= 1'b0;
      rxb_r     <= 1'b0;
      scl_drv_r <= 1'b0;
      sda_drv_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      role_r    <= role_nxt;
      cnt_r     <= cnt_nxt;
      bit_r     <= bit_nxt;
      shift_r   <= shift_nxt;
      data_r    <= data_nxt;
      code_r    <= code_nxt;
      pre_r     <= pre_nxt;
      done_r    <= done_nxt;
      start_r   <= start_nxt;
      stop_r    <= stop_nxt;
      en_r      <= en_nxt;
      acken_r   <= acken_nxt;
      wcol_r    <= wcol_nxt;
      own_r     <= own_nxt;
      addr_r    <= addr_nxt;
      rxb_r     <= rxb_nxt;
      scl_drv_r <= scl_drv_nxt;
      sda_drv_r <= sda_drv_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // code in upper bits
  assign wire_status_register = {code_r, 1'b0, pre_r};
  assign wire_data_register   = data_r;
  assign op_done              = done_r;
  assign start_pending        = start_r;
  assign stop_pending         = stop_r;
  assign write_collision      = wcol_r;
  assign bus_owned            = own_r;
  assign role                 = role_r;
  assign scl_out              = 1'b0;
  assign sda_out              = 1'b0;
  assign scl_oe_n             = !scl_drv_r;
  assign sda_oe_n             = !sda_drv_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_done_holds_scl: assert property (
    done_r |-> !scl_oe_n) else $error("SCL released while flag set");
  a_done_suspends: assert property (
    done_r |-> state_r == S_HOLD) else $error("bus moved while flag set");
  a_flag_clears: assert property (
    done_r && ctrl_write && ctrl_flag_clear && !set_ev |=> !done_r)
    else $error("flag not cleared by one");
  a_flag_keeps: assert property (
    done_r && !(ctrl_write && ctrl_flag_clear) |=> done_r)
    else $error("flag lost without clear");
  a_status_start: assert property (
    state_r == S_START3 && tick |=> done_r &&
    (wire_status_register & STATUS_MASK) inside {8'h08, 8'h10})
    else $error("bad start status");
  a_start_self_clr: assert property (
    state_r == S_START3 && tick && !ctrl_write |=> !start_r)
    else $error("start request not cleared");
  a_stop_no_flag: assert property (
    state_r == S_STOP3 && tick && !ctrl_write |=>
    !done_r && !stop_r && state_r == S_IDLE)
    else $error("stop set the flag");
  a_dir_bit: assert property (
    state_r == S_BIT_HI && addr_r && bit_r == DIR_BIT_IDX |->
    sda_oe_n == data_r[DIR_BIT]) else $error("direction bit wrong");
  a_byte_length: assert property (
    set_ev && state_r == S_BIT_HI |-> bit_r == ACK_BIT_IDX)
    else $error("byte not nine cells");
  a_role_select: assert property (
    set_ev && addr_r && state_r == S_BIT_HI |=>
    role == (data_r[DIR_BIT] ? ROLE_MASTER_RX : ROLE_MASTER_TX))
    else $error("wrong role after address");

  c_start: cover property (state_r == S_START3 && tick);
  c_addr_ack: cover property (set_ev && addr_r && sda_ack);
  c_rx_full: cover property (rxb_r && !fifo_room && state_r == S_BIT_HI);
  c_stop: cover property (state_r == S_STOP3 && tick);

endmodule

// *** include/wire_iface_pkg.sv ***
// Contract
// - Four roles: master/slave transmitter and receiver; wire_master_core only takes the two master roles.
// - Direction bit: SDA high reads, low writes.
// - Acknowledge is SDA low; high is not-acknowledge.
// - Every unit is eight bits plus acknowledge.
// - Done flag set suspends all bus activity.
// - Status code sits in upper five bits.
// - Start request sends START, then sets flag.
// - Flag rises after address and acknowledge sampled.
// - Data byte sent, acknowledge sampled, flag rises.
// - SCL held low while done flag set.
// - Writing one clears flag; zero keeps it.
// - STOP sends without setting the done flag.
// - Direction bit selects transmitter or receiver role.
package wire_iface_pkg;

  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int HALF_BIT_NS   = 5000;
  // Longest half bit, so the count rounds down.
  localparam int HALF_BIT_CYC  = HALF_BIT_NS / CLK_PERIOD_NS;

  // --------------------------------------------------------------
  // Byte framing and status layout
  // --------------------------------------------------------------
  localparam logic [3:0] ACK_BIT_IDX    = 4'h8;
  localparam logic [3:0] DIR_BIT_IDX    = 4'h7;
  localparam int         DIR_BIT        = 0;
  localparam logic       DIR_READ       = 1'b1;
  localparam logic [7:0] STATUS_MASK    = 8'hF8;
  localparam logic [1:0] PRESCALE_RESET = 2'h0;
  localparam logic [7:0] DATA_RESET     = 8'hFF;

  // Status codes, already shifted down by the three low bits.
  localparam logic [4:0] CODE_START       = 5'h01;
  localparam logic [4:0] CODE_RSTART      = 5'h02;
  localparam logic [4:0] CODE_ADDR_W_ACK  = 5'h03;
  localparam logic [4:0] CODE_ADDR_W_NACK = 5'h04;
  localparam logic [4:0] CODE_DATA_ACK    = 5'h05;
  localparam logic [4:0] CODE_DATA_NACK   = 5'h06;
  localparam logic [4:0] CODE_ADDR_R_ACK  = 5'h08;
  localparam logic [4:0] CODE_ADDR_R_NACK = 5'h09;
  localparam logic [4:0] CODE_RX_ACK      = 5'h0A;
  localparam logic [4:0] CODE_RX_NACK     = 5'h0B;
  localparam logic [4:0] CODE_IDLE        = 5'h1F;

  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_START1, S_START2, S_START3, S_BIT_LO, S_BIT_HI,
    S_HOLD, S_STOP1, S_STOP2, S_STOP3
  } state_type;

  typedef enum logic [2:0] {
    ROLE_NONE, ROLE_MASTER_TX, ROLE_MASTER_RX, ROLE_SLAVE_TX, ROLE_SLAVE_RX
  } role_type;

endpackage

// *** bench/wire_target_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bus target: acks its own address and sends a byte count.
// ------------------------------------------------------------
module wire_target_model #(
  parameter logic [6:0] ADDR = 7'h2C
) (
  // Bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            scl_pull,
  output logic            sda_pull,
  // Behaviour
  input  wire logic       nack_data,
  input  wire integer     stretch_ns,
  output logic [7:0]      got
);
  logic [7:0] shreg, tx;
  logic [3:0] n;
  logic       adr, rd, act;

  // An idle target leaves both lines to the pull-ups.
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    act = 1'b0;
    rd = 1'b0;
    adr = 1'b0;
    tx = 8'hC3;
    got = 8'h00;
  end

  // Frame edges are judged 1 ns late, because the master moves
  // both lines in one time step when it lowers the clock.
  always @(sda) begin
    #1;
    if (scl === 1'b1) begin
      act = !sda;
      adr = 1'b1;
      rd = 1'b0;
      n = 4'hF;
      sda_pull = 1'b0;
    end
  end

  always @(posedge scl) begin
    if (act && n < 4'h8) begin
      shreg = {shreg[6:0], sda};
    end else if (act && rd && !adr && sda === 1'b1) begin
      rd = 1'b0;
    end
  end

  // Data moves only while the clock is low.
  always @(negedge scl) begin
    if (act) begin
      n = n + 4'h1;
      if (n == 4'h8) begin
        if (!rd || adr) begin
          got = shreg;
          sda_pull = adr ? (shreg[7:1] == ADDR) : !nack_data;
        end else begin
          sda_pull = 1'b0;
          tx = tx + 8'h01;
        end
      end else if (n == 4'h9) begin
        n = 4'h0;
        if (adr) begin
          rd = shreg[0] && (shreg[7:1] == ADDR);
          adr = 1'b0;
        end
        sda_pull = rd && !tx[7];
      end else begin
        sda_pull = rd && !adr && !tx[4'h7 - n];
      end
      // A slow target stretches the low phase.
      if (stretch_ns > 0) begin
        scl_pull = 1'b1;
        #(stretch_ns);
        scl_pull = 1'b0;
      end
    end
  end
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`define check(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) begin \
      n_errors++; \
      $display("wrong value %s exp %h got %h", nm, e, g); \
    end \
  end
module tb_top;
  import wire_iface_pkg::*;
  localparam int         HC = 4;
  localparam logic [1:0] PS = 2'h1;

  // Design side
  logic       clk, reset_n, ctrl_write, ctrl_flag_clear, ctrl_start;
  logic       ctrl_stop, ctrl_enable, ctrl_ack_en, data_write, rx_ready;
  logic [1:0] ctrl_prescale;
  logic [7:0] data_in, stat, dr, rx_data, got;
  logic       op_done, start_pending, stop_pending, write_collision;
  logic       bus_owned, rx_valid, scl_oe_n, sda_oe_n;
  role_type   role;
  // Bus and target
  logic       scl_pull, sda_pull, nack_data;
  int         stretch_ns, n_errors, total_checks;
  wire logic  scl_w, sda_w;

  // Open drain with pull-ups: a line is low if anyone pulls it.
  assign scl_w = scl_oe_n & ~scl_pull;
  assign sda_w = sda_oe_n & ~sda_pull;

  wire_master_core #(.HALF_CYC(HC)) uut (
    .clk(clk), .reset_n(reset_n), .ctrl_write(ctrl_write),
    .ctrl_flag_clear(ctrl_flag_clear), .ctrl_start(ctrl_start),
    .ctrl_stop(ctrl_stop), .ctrl_enable(ctrl_enable),
    .ctrl_ack_en(ctrl_ack_en), .ctrl_prescale(ctrl_prescale),
    .data_write(data_write), .data_in(data_in), .op_done(op_done),
    .start_pending(start_pending), .stop_pending(stop_pending),
    .write_collision(write_collision), .bus_owned(bus_owned),
    .wire_status_register(stat), .wire_data_register(dr), .role(role),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .scl_in(scl_w), .scl_out(), .scl_oe_n(scl_oe_n),
    .sda_in(sda_w), .sda_out(), .sda_oe_n(sda_oe_n));

  wire_target_model target (
    .scl(scl_w), .sda(sda_w), .scl_pull(scl_pull), .sda_pull(sda_pull),
    .nack_data(nack_data), .stretch_ns(stretch_ns), .got(got));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Inputs always move 1 ns after the rising edge.
  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic ctrl(input logic c, input logic s, input logic p,
                      input logic a);
    step();
    ctrl_write = 1'b1;
    ctrl_flag_clear = c;
    ctrl_start = s;
    ctrl_stop = p;
    ctrl_enable = 1'b1;
    ctrl_ack_en = a;
    ctrl_prescale = PS;
    step();
    ctrl_write = 1'b0;
  endtask

  task automatic wait_done(input logic [4:0] code);
    int i;
    for (i = 0; i < 3000 && op_done !== 1'b1; i++) step();
    if (i == 3000) begin
      n_errors++;
      finish_test();
    end
    `check("status", {code, 1'b0, PS}, stat)
    `check("code", {code, 3'h0}, stat & STATUS_MASK)
  endtask

  task automatic send(input logic [7:0] b, input logic a);
    step();
    data_write = 1'b1;
    data_in = b;
    step();
    data_write = 1'b0;
    ctrl(1'b1, 1'b0, 1'b0, a);
  endtask

  task automatic pop(input logic [7:0] b);
    step();
    `check("rx_valid", 1'b1, rx_valid)
    `check("rx_data", b, rx_data)
    rx_ready = 1'b1;
    step();
    rx_ready = 1'b0;
  endtask

  task automatic hold(input int cyc);
    logic s;
    s = sda_oe_n;
    repeat (cyc) begin
      step();
      `check("done_hold", 1'b1, op_done)
      `check("scl_hold", 1'b0, scl_oe_n)
      `check("sda_hold", s, sda_oe_n)
    end
  endtask

  task automatic stop_check();
    ctrl(1'b1, 1'b0, 1'b1, 1'b0);
    repeat (200) begin
      step();
      `check("no_flag", 1'b0, op_done)
    end
    `check("stop_pend", 1'b0, stop_pending)
    `check("owned", 1'b0, bus_owned)
    `check("sda_free", 1'b1, sda_w)
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    `check("done", 1'b0, op_done)
    `check("status", 8'hF8, stat)
    `check("data", 8'hFF, dr)
    `check("role", ROLE_NONE, role)
    `check("scl", 1'b1, scl_oe_n)
  endtask

  task automatic t_write();
    ctrl(1'b1, 1'b1, 1'b0, 1'b0);
    wait_done(CODE_START);
    `check("start_pend", 1'b0, start_pending)
    `check("owned", 1'b1, bus_owned)
    ctrl(1'b0, 1'b0, 1'b0, 1'b0);
    hold(20);
    send(8'h58, 1'b0);
    step();
    data_write = 1'b1;
    data_in = 8'h00;
    step();
    data_write = 1'b0;
    step();
    `check("collision", 1'b1, write_collision)
    wait_done(CODE_ADDR_W_ACK);
    `check("role", ROLE_MASTER_TX, role)
    `check("addr_seen", 8'h58, got)
    // Off the clock edge, so the release never races the synchroniser.
    stretch_ns = 202;
    send(8'hA7, 1'b0);
    wait_done(CODE_DATA_ACK);
    `check("collision", 1'b0, write_collision)
    `check("byte_seen", 8'hA7, got)
    nack_data = 1'b1;
    send(8'h3C, 1'b0);
    wait_done(CODE_DATA_NACK);
    nack_data = 1'b0;
    stretch_ns = 0;
    stop_check();
  endtask

  task automatic t_nack();
    ctrl(1'b1, 1'b1, 1'b0, 1'b0);
    wait_done(CODE_START);
    send(8'h3A, 1'b0);
    wait_done(CODE_ADDR_W_NACK);
    stop_check();
  endtask

  // Two bytes fill the buffer; the third must wait for a pop.
  task automatic t_read();
    ctrl(1'b1, 1'b1, 1'b0, 1'b0);
    wait_done(CODE_START);
    send(8'h58, 1'b0);
    wait_done(CODE_ADDR_W_ACK);
    ctrl(1'b1, 1'b1, 1'b0, 1'b0);
    wait_done(CODE_RSTART);
    send(8'h59, 1'b1);
    wait_done(CODE_ADDR_R_ACK);
    `check("role", ROLE_MASTER_RX, role)
    `check("addr_seen", 8'h59, got)
    ctrl(1'b1, 1'b0, 1'b0, 1'b1);
    wait_done(CODE_RX_ACK);
    ctrl(1'b1, 1'b0, 1'b0, 1'b1);
    wait_done(CODE_RX_ACK);
    ctrl(1'b1, 1'b0, 1'b0, 1'b1);
    repeat (300) begin
      step();
      `check("full_stall", 1'b0, op_done)
    end
    pop(8'hC3);
    wait_done(CODE_RX_ACK);
    pop(8'hC4);
    pop(8'hC5);
    step();
    `check("rx_empty", 1'b0, rx_valid)
    ctrl(1'b1, 1'b0, 1'b0, 1'b0);
    wait_done(CODE_RX_NACK);
    `check("rx_last", 8'hC6, dr)
    pop(8'hC6);
    stop_check();
  endtask

  // Dropping enable while held lets go of the bus without a STOP.
  task automatic t_disable();
    ctrl(1'b1, 1'b1, 1'b0, 1'b0);
    wait_done(CODE_START);
    step();
    ctrl_write = 1'b1;
    ctrl_flag_clear = 1'b1;
    ctrl_start = 1'b0;
    ctrl_stop = 1'b0;
    ctrl_enable = 1'b0;
    step();
    ctrl_write = 1'b0;
    repeat (8) step();
    `check("dis_done", 1'b0, op_done)
    `check("dis_owned", 1'b0, bus_owned)
    `check("dis_role", ROLE_NONE, role)
    `check("dis_scl", 1'b1, scl_w)
    `check("dis_sda", 1'b1, sda_w)
  endtask

  // 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    {reset_n, ctrl_write, ctrl_flag_clear, ctrl_start} = 4'h0;
    {ctrl_stop, ctrl_enable, ctrl_ack_en, data_write} = 4'h0;
    {rx_ready, nack_data} = 2'h0;
    ctrl_prescale = 2'h0;
    data_in = 8'h00;
    stretch_ns = 0;
    n_errors = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_write();
    t_nack();
    t_disable();
    t_read();
    finish_test();
  end
endmodule
